// ### dzpg_pkg.sv
package dzpg_pkg;
  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned DZPG_AW = 8;
  localparam int unsigned DZPG_NMOD = 8;
  localparam logic [7:0] DZPG_OFS_CLOCK_DIVIDER_REGISTER = 8'h00;
  localparam logic [7:0] DZPG_OFS_PWROFF = 8'h04;
  localparam logic [7:0] DZPG_OFS_MODEN = 8'h08;
  localparam logic [7:0] DZPG_OFS_IDLSTOP = 8'h0c;
  localparam logic [7:0] DZPG_OFS_CTRL = 8'h10;
  localparam logic [7:0] DZPG_OFS_STATUS = 8'h14;
  // ----------------------------------------------------------------
  // clock divider register fields
  // ----------------------------------------------------------------
  localparam int unsigned DZPG_ROI_BIT = 15;
  localparam int unsigned DZPG_RATIO_HI = 14;
  localparam int unsigned DZPG_RATIO_LO = 12;
  localparam int unsigned DZPG_CPU_SLOWDOWN_ENABLE_BIT = 11;
  localparam logic [2:0] DZPG_RATIO_RST = 3'h0;
  localparam logic [7:0] DZPG_MODEN_RST = 8'hff;
  localparam logic [7:0] DZPG_ZERO8 = 8'h00;
  localparam logic [6:0] DZPG_CNT_ONE = 7'h01;
  localparam logic [6:0] DZPG_CNT_ZERO = 7'h00;
  localparam logic [31:0] DZPG_BAD_DATA = 32'hdead_beef;
  localparam int unsigned DZPG_IDLE_BIT = 0;
  localparam int unsigned DZPG_ST_DOZE = 0;
  localparam int unsigned DZPG_ST_IDLE = 1;
  localparam int unsigned DZPG_ST_EN = 2;
endpackage

// ### dzpg_core_div.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// cpu clock pulse generator: one enable per 2**ratio system cycles
// ------------------------------------------------------------------
module dzpg_core_div
  import dzpg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic doze_on,
  input wire logic [2:0] ratio,
  // output
  output logic cpu_tick
);
  typedef struct packed {
    logic [6:0] cnt;
  } dzpg_div_t;

  dzpg_div_t st_reg;
  dzpg_div_t st_next;
  logic [6:0] last;

  // ratio n selects divide by two to the power n
  assign last = 7'((8'h01 << ratio) - 8'h01);
  // pulses are cut from the system clock, so both domains share edges
  assign cpu_tick = !doze_on || (st_reg.cnt == last);

  always_comb
  begin
    st_next = st_reg;
    if (!doze_on || st_reg.cnt >= last)
      st_next.cnt = DZPG_CNT_ZERO;
    else
      st_next.cnt = st_reg.cnt + DZPG_CNT_ONE;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  a_tick_full_speed: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !doze_on |-> cpu_tick)
    else $error("cpu tick missing at full speed");
  a_tick_ratio_two: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (doze_on && ratio == 3'h1 && cpu_tick) ##1 (doze_on && ratio == 3'h1)
    |-> !cpu_tick)
    else $error("ratio one ticks twice in a row");
endmodule
`default_nettype wire

// ### dzpg_top.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - slowdown leaves the system and peripheral clocks at full rate.
// - the slowed cpu clock stays aligned to the peripheral clock.
// - bit 11 of the clock divider register enables slowdown.
// - bits 14..12 pick one of eight ratios, 1:1 after reset.
// - with bit 15 set an interrupt restores full cpu speed.
// - with bit 15 clear interrupts leave slowdown untouched.
// - idle stops the cpu clock while peripherals keep theirs.
// - a module power-off bit gates every clock of that module.
// - while powered off, module writes drop and reads give junk.
// - clearing module enable stops function, registers stay usable.
// - a stop-in-idle bit disables the module during idle.
// - stop-in-idle bits reset clear, so modules run in idle.
module dzpg_top
  import dzpg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dzpg_pkg::DZPG_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // events from the core
  input wire logic irq_event,
  // cpu and peripheral clock enables
  output logic cpu_clk_en,
  output logic periph_clk_en,
  // per-module gating
  output logic [dzpg_pkg::DZPG_NMOD-1:0] mod_clk_en,
  output logic [dzpg_pkg::DZPG_NMOD-1:0] mod_run,
  output logic [dzpg_pkg::DZPG_NMOD-1:0] mod_reg_access,
  // module register port filter
  input wire logic [2:0] mod_sel,
  input wire logic mod_wr_req,
  input wire logic [31:0] mod_rdata_in,
  output logic mod_wr_ok,
  output logic [31:0] mod_rdata_out
);
  import dzpg_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic return_on_interrupt;
    logic [2:0] ratio;
    logic cpu_slowdown_enable;
    logic [7:0] pwroff;
    logic [7:0] moden;
    logic [7:0] idlstop;
    logic idle;
    logic [31:0] rdata;
    logic [7:0] clk_en;
    logic [7:0] run;
  } dzpg_state_t;

  dzpg_state_t st_reg;
  dzpg_state_t st_next;
  logic tick;
  logic wr_acc;
  logic rd_acc;
  logic mapped;

  function automatic logic [31:0] dzpg_zx8(input logic [7:0] v);
    dzpg_zx8 = {24'h000000, v};
  endfunction

  // ----------------------------------------------------------------
  // cpu divider
  // ----------------------------------------------------------------
  dzpg_core_div u_div (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .doze_on(st_reg.cpu_slowdown_enable),
    .ratio(st_reg.ratio),
    .cpu_tick(tick)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  always_comb
  begin
    case (paddr)
      DZPG_OFS_CLOCK_DIVIDER_REGISTER, DZPG_OFS_PWROFF, DZPG_OFS_MODEN,
      DZPG_OFS_IDLSTOP, DZPG_OFS_CTRL, DZPG_OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;
  assign prdata = st_reg.rdata;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    if (wr_acc)
    begin
      case (paddr)
        DZPG_OFS_CLOCK_DIVIDER_REGISTER:
        begin
          st_next.return_on_interrupt = pwdata[DZPG_ROI_BIT];
          st_next.ratio = pwdata[DZPG_RATIO_HI:DZPG_RATIO_LO];
          st_next.cpu_slowdown_enable = pwdata[DZPG_CPU_SLOWDOWN_ENABLE_BIT];
        end
        DZPG_OFS_PWROFF: st_next.pwroff = pwdata[7:0];
        DZPG_OFS_MODEN: st_next.moden = pwdata[7:0];
        DZPG_OFS_IDLSTOP: st_next.idlstop = pwdata[7:0];
        DZPG_OFS_CTRL: st_next.idle = pwdata[DZPG_IDLE_BIT];
        default: st_next.idle = st_reg.idle;
      endcase
    end
    // an interrupt also wakes the core out of idle
    if (irq_event)
      st_next.idle = 1'b0;
    // event beats a same-cycle software write of the enable only when that write sets roi
    if (irq_event && st_next.return_on_interrupt)
      st_next.cpu_slowdown_enable = 1'b0;
    // with roi clear nothing here touches cpu_slowdown_enable or ratio
    if (rd_acc)
    begin
      case (paddr)
        DZPG_OFS_CLOCK_DIVIDER_REGISTER:
        begin
          st_next.rdata = '0;
          st_next.rdata[DZPG_ROI_BIT] = st_reg.return_on_interrupt;
          st_next.rdata[DZPG_RATIO_HI:DZPG_RATIO_LO] = st_reg.ratio;
          st_next.rdata[DZPG_CPU_SLOWDOWN_ENABLE_BIT] = st_reg.cpu_slowdown_enable;
        end
        DZPG_OFS_PWROFF: st_next.rdata = dzpg_zx8(st_reg.pwroff);
        DZPG_OFS_MODEN: st_next.rdata = dzpg_zx8(st_reg.moden);
        DZPG_OFS_IDLSTOP: st_next.rdata = dzpg_zx8(st_reg.idlstop);
        DZPG_OFS_CTRL:
          st_next.rdata = dzpg_zx8({7'h00, st_reg.idle});
        DZPG_OFS_STATUS:
        begin
          st_next.rdata = '0;
          st_next.rdata[DZPG_ST_DOZE] = st_reg.cpu_slowdown_enable;
          st_next.rdata[DZPG_ST_IDLE] = st_reg.idle;
          st_next.rdata[DZPG_ST_EN] = cpu_clk_en;
        end
        default: st_next.rdata = '0;
      endcase
    end
    // power-off gates every clock; slowdown never touches these
    st_next.clk_en = ~st_next.pwroff;
    // idle disables a module only where its stop bit is set
    st_next.run = st_next.moden & ~st_next.pwroff
      & ~(st_next.idle ? st_next.idlstop : DZPG_ZERO8);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
      st_reg.ratio <= DZPG_RATIO_RST;
      st_reg.moden <= DZPG_MODEN_RST;
      st_reg.clk_en <= DZPG_MODEN_RST;
      st_reg.run <= DZPG_MODEN_RST;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cpu_clk_en = tick && !st_reg.idle;
  assign periph_clk_en = 1'b1;
  assign mod_clk_en = st_reg.clk_en;
  assign mod_run = st_reg.run;
  // register access survives a cleared enable, not a power-off
  assign mod_reg_access = ~st_reg.pwroff;
  assign mod_wr_ok = mod_wr_req && !st_reg.pwroff[mod_sel];
  assign mod_rdata_out = st_reg.pwroff[mod_sel] ? DZPG_BAD_DATA
    : mod_rdata_in;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_clock_divider_register_wr;
    wr_acc && paddr == DZPG_OFS_CLOCK_DIVIDER_REGISTER;
  endsequence

  a_doze_enable_wr: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_clock_divider_register_wr and (pwdata[DZPG_CPU_SLOWDOWN_ENABLE_BIT] && !irq_event)
    |=> st_reg.cpu_slowdown_enable)
    else $error("slowdown enable not taken");
  a_ratio_wr: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_clock_divider_register_wr
    |=> st_reg.ratio == $past(pwdata[DZPG_RATIO_HI:DZPG_RATIO_LO]))
    else $error("ratio field not stored");
  a_roi_wake: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (irq_event && st_reg.return_on_interrupt && !wr_acc) |=> !st_reg.cpu_slowdown_enable ##0 cpu_clk_en
    || st_reg.idle)
    else $error("interrupt did not restore full speed");
  a_no_roi_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (irq_event && !st_reg.return_on_interrupt && !wr_acc)
    |=> $stable(st_reg.cpu_slowdown_enable) && $stable(st_reg.ratio))
    else $error("interrupt changed slowdown with roi clear");
  a_idle_stop: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    st_reg.idle |-> !cpu_clk_en && periph_clk_en)
    else $error("cpu clock runs in idle");
  a_pwroff_gate: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(st_reg.pwroff[0]) |-> !mod_clk_en[0] && !mod_run[0]
    && !mod_reg_access[0])
    else $error("powered-off module still clocked");
  a_pwroff_wr: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    st_reg.pwroff[mod_sel] |-> !mod_wr_ok
    && mod_rdata_out == DZPG_BAD_DATA)
    else $error("powered-off module register reachable");
  a_moden_off: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!st_reg.moden[3] && !st_reg.pwroff[3])
    |-> !mod_run[3] && mod_reg_access[3])
    else $error("disabled module lost registers or kept running");
  a_idle_module: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (st_reg.idle && st_reg.idlstop[2]) |-> !mod_run[2])
    else $error("module kept running in idle");
  a_idle_default: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (st_reg.idle && !st_reg.idlstop[3] && st_reg.moden[3]
    && !st_reg.pwroff[3]) |-> mod_run[3])
    else $error("module stopped in idle by default");

  // ----------------------------------------------------------------
  // derived checks
  // ----------------------------------------------------------------
  // each step of a register access, and the slowed state, named once and reused below
  sequence s_clock_divider_register_rd;
    rd_acc && paddr == DZPG_OFS_CLOCK_DIVIDER_REGISTER;
  endsequence
  sequence s_status_rd;
    rd_acc && paddr == DZPG_OFS_STATUS;
  endsequence
  sequence s_ctrl_wr;
    wr_acc && paddr == DZPG_OFS_CTRL;
  endsequence
  sequence s_pwroff_wr;
    wr_acc && paddr == DZPG_OFS_PWROFF;
  endsequence
  sequence s_moden_wr;
    wr_acc && paddr == DZPG_OFS_MODEN;
  endsequence
  sequence s_slowed;
    st_reg.cpu_slowdown_enable && st_reg.ratio != DZPG_RATIO_RST;
  endsequence

  a_periph_steady: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    st_reg.cpu_slowdown_enable |-> periph_clk_en && mod_clk_en == ~st_reg.pwroff)
    else $error("slowdown reached a peripheral clock");
  a_tick_gap: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (s_slowed ##0 cpu_clk_en) ##1 (s_slowed ##0 $stable(st_reg.ratio))
    |-> !cpu_clk_en)
    else $error("cpu tick repeated while slowed");
  a_full_speed: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!st_reg.cpu_slowdown_enable && !st_reg.idle) |-> cpu_clk_en)
    else $error("cpu clock slowed with slowdown off");
  a_doze_clear_wr: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_clock_divider_register_wr and (!pwdata[DZPG_CPU_SLOWDOWN_ENABLE_BIT]) |=> !st_reg.cpu_slowdown_enable)
    else $error("slowdown enable not cleared");
  a_clock_divider_register_rd: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_clock_divider_register_rd
    |=> prdata[DZPG_RATIO_HI:DZPG_RATIO_LO] == $past(st_reg.ratio)
    && prdata[DZPG_ROI_BIT] == $past(st_reg.return_on_interrupt)
    && prdata[DZPG_CPU_SLOWDOWN_ENABLE_BIT] == $past(st_reg.cpu_slowdown_enable))
    else $error("clock divider read back wrong");
  a_ratio_irq: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (irq_event && !wr_acc) |=> $stable(st_reg.ratio))
    else $error("interrupt changed the ratio");
  a_roi_race: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_clock_divider_register_wr and (pwdata[DZPG_ROI_BIT] && irq_event) |=> !st_reg.cpu_slowdown_enable)
    else $error("same-cycle write beat the interrupt");
  a_roi_store: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_clock_divider_register_wr |=> st_reg.return_on_interrupt == $past(pwdata[DZPG_ROI_BIT]))
    else $error("return-on-interrupt bit not stored");
  a_status_rd: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_status_rd |=> prdata[DZPG_ST_IDLE] == $past(st_reg.idle)
    && prdata[DZPG_ST_EN] == $past(cpu_clk_en)
    && prdata[DZPG_ST_DOZE] == $past(st_reg.cpu_slowdown_enable))
    else $error("status read back wrong");
  a_idle_enter: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_ctrl_wr and (pwdata[DZPG_IDLE_BIT] && !irq_event)
    |=> st_reg.idle && !cpu_clk_en)
    else $error("idle request did not stop the cpu");
  a_idle_wake: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    irq_event |=> !st_reg.idle)
    else $error("interrupt left the core idle");
  a_pwroff_store: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_pwroff_wr |=> mod_clk_en == ~$past(pwdata[DZPG_NMOD-1:0]))
    else $error("power-off write did not gate clocks");
  a_pwroff_quiet: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (st_reg.pwroff & (mod_run | mod_reg_access)) == DZPG_ZERO8)
    else $error("powered-off module still active");
  a_open_access: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !st_reg.pwroff[mod_sel]
    |-> mod_wr_ok == mod_wr_req && mod_rdata_out == mod_rdata_in)
    else $error("powered module register port blocked");
  a_moden_apply: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_moden_wr |=> (mod_run & ~$past(pwdata[DZPG_NMOD-1:0])) == DZPG_ZERO8)
    else $error("cleared enable left a module running");
  a_run_awake: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !st_reg.idle |-> mod_run == (st_reg.moden & ~st_reg.pwroff))
    else $error("awake module run state wrong");
  a_idle_stop_all: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    st_reg.idle |-> (mod_run & st_reg.idlstop) == DZPG_ZERO8)
    else $error("stop-in-idle module kept running");
  a_idle_keep_all: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    st_reg.idle
    |-> mod_run == (st_reg.moden & ~st_reg.pwroff & ~st_reg.idlstop))
    else $error("idle stopped a module without its stop bit");
endmodule
`default_nettype wire

// ### dzpg_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// cpu core and peripheral side: counts clock enables it receives
// ------------------------------------------------------------------
module dzpg_cpu_model
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // gated enables from the block
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  // counting window
  input wire logic clr,
  output logic [15:0] cpu_ticks,
  output logic [15:0] periph_miss
);
  // a peripheral cycle lost while the core is slowed is a fault
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpu_ticks <= 16'h0000;
      periph_miss <= 16'h0000;
    end
    else if (clr)
    begin
      cpu_ticks <= 16'h0000;
      periph_miss <= 16'h0000;
    end
    else
    begin
      cpu_ticks <= cpu_ticks + {15'h0000, cpu_clk_en};
      periph_miss <= periph_miss + {15'h0000, !periph_clk_en};
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dzpg_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq_event = 1'b0, clr = 1'b1;
  logic cpu_clk_en, periph_clk_en, mod_wr_req = 1'b0, mod_wr_ok;
  logic [7:0] paddr = 8'h00, mod_clk_en, mod_run, mod_reg_access;
  logic [31:0] pwdata = 32'h0, prdata, mod_rdata_out;
  logic [31:0] mod_rdata_in = 32'h1234_5678;
  logic [2:0] mod_sel = 3'h0;
  logic [15:0] cpu_ticks, periph_miss;
  int bad_count = 0, checks = 0;
  always #20 ref_clk = ~ref_clk;
  dzpg_top dzpg_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_event(irq_event), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .mod_clk_en(mod_clk_en),
    .mod_run(mod_run), .mod_reg_access(mod_reg_access),
    .mod_sel(mod_sel), .mod_wr_req(mod_wr_req),
    .mod_rdata_in(mod_rdata_in), .mod_wr_ok(mod_wr_ok),
    .mod_rdata_out(mod_rdata_out));
  dzpg_cpu_model dzpg_cpu_model_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .clr(clr),
    .cpu_ticks(cpu_ticks), .periph_miss(periph_miss));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("mismatches %0d of %0d comparisons", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
        exp);
    end
  endtask
  // read data and error are taken at the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp, "read");
    chk({31'h0, e}, {31'h0, a > DZPG_OFS_STATUS}, "error");
  endtask
  task automatic cnt(input int cyc, input logic [15:0] exp);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (cyc) @(posedge ref_clk);
    #1;
    chk({16'h0, cpu_ticks}, {16'h0, exp}, "cpu ticks");
    chk({16'h0, periph_miss}, 32'h0, "periph gaps");
  endtask
  task automatic irq;
    @(posedge ref_clk);
    irq_event <= 1'b1;
    @(posedge ref_clk);
    irq_event <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic filt(input logic [2:0] s, input logic ok,
    input logic [31:0] dat);
    @(posedge ref_clk);
    mod_sel <= s;
    mod_wr_req <= 1'b1;
    #1;
    chk({31'h0, mod_wr_ok}, {31'h0, ok}, "write pass");
    chk(mod_rdata_out, dat, "module read");
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict;
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(DZPG_OFS_CLOCK_DIVIDER_REGISTER, 32'h0, 32'hffff_ffff);
    rd(DZPG_OFS_IDLSTOP, 32'h0, 32'hffff_ffff);
    rd(DZPG_OFS_MODEN, 32'hff, 32'hffff_ffff);
    rd(DZPG_OFS_PWROFF, 32'h0, 32'hffff_ffff);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    cnt(256, 16'd256);
    for (int n = 0; n < 8; n++)
    begin
      wr(DZPG_OFS_CLOCK_DIVIDER_REGISTER, 32'h800 | (n << 12));
      rd(DZPG_OFS_CLOCK_DIVIDER_REGISTER, 32'h800 | (n << 12), 32'hffff);
      cnt(256, 16'(256 >> n));
    end
    irq;
    rd(DZPG_OFS_STATUS, 32'h1, 32'h1);
    cnt(256, 16'd2);
    wr(DZPG_OFS_CLOCK_DIVIDER_REGISTER, 32'hb800);
    irq;
    rd(DZPG_OFS_STATUS, 32'h0, 32'h1);
    rd(DZPG_OFS_CLOCK_DIVIDER_REGISTER, 32'hb000, 32'hffff);
    cnt(256, 16'd256);
    wr(DZPG_OFS_IDLSTOP, 32'h04);
    wr(DZPG_OFS_CTRL, 32'h1);
    rd(DZPG_OFS_STATUS, 32'h2, 32'h6);
    rd(DZPG_OFS_CTRL, 32'h1, 32'hffff_ffff);
    cnt(64, 16'd0);
    chk({24'h0, mod_run}, 32'hfb, "idle run");
    irq;
    chk({24'h0, mod_run}, 32'hff, "wake run");
    wr(DZPG_OFS_PWROFF, 32'h01);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({24'h0, mod_clk_en}, 32'hfe, "clock gate");
    chk({24'h0, mod_reg_access}, 32'hfe, "access");
    filt(3'h0, 1'b0, DZPG_BAD_DATA);
    filt(3'h1, 1'b1, mod_rdata_in);
    wr(DZPG_OFS_MODEN, 32'hf7);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({24'h0, mod_run}, 32'hf6, "enable run");
    filt(3'h3, 1'b1, mod_rdata_in);
    rd(DZPG_OFS_MODEN, 32'hf7, 32'hffff_ffff);
    print_verdict;
  end
endmodule
`default_nettype wire
